// >>> rtl/ams_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "ams_regs.svh"

module ams_top
	import ams_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [31:0] rdata,
	input  wire logic [3:0]  dip_switch,
	input  wire logic        switch_disable_key,
	input  wire logic        enable_in,
	input  wire logic        clock_in,
	input  wire logic        direction_in,
	input  wire logic [11:0] analog_code,
	input  wire logic        setup_done,
	input  wire logic        setup_ok,
	input  wire logic        setup_index_found,
	output logic             setup_run,
	output logic             param_commit,
	output logic             store_drive,
	output logic             store_tuning,
	output logic             limits_active,
	output logic             power_enabled,
	output logic             closed_loop,
	output logic             velocity_mode,
	output logic             step_pulse,
	output logic             step_dir
);

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [7:0] pin_meta;
	logic [7:0] pin_sync;
	logic       clk_prev;

	// The switch, key, enable, clock and direction pins pass two flops before any logic reads them
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta <= 8'h00;
			pin_sync <= 8'h00;
		end else begin
			pin_meta <= {switch_disable_key, direction_in, clock_in, enable_in, dip_switch};
			pin_sync <= pin_meta;
		end
	end

	wire logic [3:0] sw_s   = pin_sync[3:0];
	wire logic       en_s   = pin_sync[4];
	wire logic       clk_s  = pin_sync[5];
	wire logic       dir_s  = pin_sync[6];
	wire logic       key_s  = pin_sync[7];

	// Previous clock pin level; idles low like the pin, so no edge after reset
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			clk_prev <= 1'b0;
		end else begin
			clk_prev <= clk_s;
		end
	end

	// ****************************************
	// Switch capture at restart
	// ****************************************
	function automatic ams_mode_e decode_mode(input logic [3:0] sw, input logic key);
		if (key) begin
			decode_mode = AMS_MODE_NONE;
		end else if (sw[0]) begin
			decode_mode = AMS_MODE_ANALOG;
		end else if (sw[1]) begin
			decode_mode = AMS_MODE_TEST;
		end else begin
			decode_mode = AMS_MODE_CLKDIR;
		end
	endfunction

	logic [1:0] settle_cnt;
	logic       sw_taken;
	logic [3:0] sw_latched;
	ams_mode_e  mode;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			settle_cnt <= 2'h0;
			sw_taken   <= 1'b0;
			sw_latched <= 4'h0;
			mode       <= AMS_MODE_NONE;
		end else if (!sw_taken) begin
			// Wait out the synchroniser so real pin levels are latched
			if (settle_cnt == `AMS_SETTLE_CYCLES) begin
				sw_taken   <= 1'b1;
				// A set disable key leaves every switch reading off
				sw_latched <= key_s ? 4'h0 : sw_s;
				mode       <= decode_mode(sw_s, key_s);
			end else begin
				settle_cnt <= settle_cnt + 2'h1;
			end
		end
	end

	// Any special drive mode takes the power state away from the controlword
	wire logic special = (mode != AMS_MODE_NONE);

	// ****************************************
	// Register file
	// ****************************************
	logic [15:0] ctrlword;
	logic [7:0]  opmode;
	logic [7:0]  progctl;
	logic [15:0] scale_num;
	logic [15:0] scale_den;
	logic [31:0] target_vel;
	logic        oms_prev;
	logic        setup_ended;
	logic        index_found;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ctrlword  <= `AMS_CTRLWORD_RST;
			opmode    <= `AMS_OPMODE_RST;
			progctl   <= `AMS_PROGCTL_RST;
			scale_num <= `AMS_SCALE_NUM_RST;
			scale_den <= `AMS_SCALE_DEN_RST;
		end else if (wr) begin
			unique case (addr)
				`AMS_ADDR_CTRLWORD:  ctrlword  <= wdata[15:0];
				`AMS_ADDR_OPMODE:    opmode    <= wdata[7:0];
				`AMS_ADDR_PROGCTL:   progctl   <= wdata[7:0];
				`AMS_ADDR_SCALE_NUM: scale_num <= wdata[15:0];
				`AMS_ADDR_SCALE_DEN: scale_den <= wdata[15:0];
				// Statusword and unmapped offsets ignore writes
				default: ;
			endcase
		end
	end

	logic [15:0] statusword;

	always_comb begin
		statusword                   = 16'h0000;
		statusword[`AMS_SW_OMS_BIT]  = setup_ended;
		statusword[`AMS_SW_TARGET_REACHED_BIT_BIT] = index_found;
		statusword[`AMS_SW_OPEN_BIT] = power_enabled;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 32'h0000_0000;
		end else if (rd) begin
			unique case (addr)
				`AMS_ADDR_CTRLWORD:   rdata <= {16'h0000, ctrlword};
				`AMS_ADDR_STATUSWORD: rdata <= {16'h0000, statusword};
				`AMS_ADDR_OPMODE:     rdata <= {24'h000000, opmode};
				`AMS_ADDR_PROGCTL:    rdata <= {24'h000000, progctl};
				`AMS_ADDR_SCALE_NUM:  rdata <= {16'h0000, scale_num};
				`AMS_ADDR_SCALE_DEN:  rdata <= {16'h0000, scale_den};
				`AMS_ADDR_TARGET_VEL: rdata <= target_vel;
				`AMS_ADDR_DRIVE_STAT: rdata <= {20'h00000, sw_latched, mode, 3'b000, sw_taken};
				default:              rdata <= 32'h0000_0000;
			endcase
		end else begin
			rdata <= 32'h0000_0000;
		end
	end

	// ****************************************
	// Power state
	// ****************************************
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			power_enabled <= 1'b0;
		end else if (special) begin
			power_enabled <= en_s;
		end else begin
			// Simplified state machine: operation enabled when low nibble is all ones
			power_enabled <= (ctrlword[`AMS_CW_STATE_MSB:0] == `AMS_CW_ENABLE_OP);
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			closed_loop   <= 1'b0;
			velocity_mode <= 1'b0;
			limits_active <= 1'b0;
		end else begin
			// Closed loop follows switch 4 as latched at restart
			closed_loop   <= sw_latched[3];
			velocity_mode <= (mode == AMS_MODE_ANALOG) || (mode == AMS_MODE_TEST);
			// Range limits are never switched off, auto setup included
			limits_active <= 1'b1;
		end
	end

	// ****************************************
	// Auto setup sequence
	// ****************************************
	ams_setup_e as_state;
	wire logic  oms_rise = ctrlword[`AMS_CW_OMS_BIT] && !oms_prev;
	wire logic  prog_stopped = !progctl[`AMS_PROG_RUN_BIT];
	wire logic  setup_armed  = (opmode == `AMS_OPMODE_AUTOSET) && power_enabled;
	// Only a fresh rising start bit begins a run; refused in special modes
	wire logic  as_start     = (as_state == AMS_AS_IDLE) && !special && oms_rise
		&& setup_armed && prog_stopped;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			oms_prev <= 1'b0;
		end else begin
			oms_prev <= ctrlword[`AMS_CW_OMS_BIT];
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			as_state     <= AMS_AS_IDLE;
			setup_run    <= 1'b0;
			param_commit <= 1'b0;
			store_drive  <= 1'b0;
			store_tuning <= 1'b0;
		end else begin
			param_commit <= 1'b0;
			store_drive  <= 1'b0;
			store_tuning <= 1'b0;
			unique case (as_state)
				AMS_AS_IDLE: begin
					if (as_start) begin
						as_state  <= AMS_AS_RUN;
						setup_run <= 1'b1;
					end
				end
				AMS_AS_RUN: begin
					if (setup_done) begin
						setup_run <= 1'b0;
						as_state  <= setup_ok ? AMS_AS_STORE : AMS_AS_IDLE;
					end else if (!power_enabled) begin
						// Losing operation enabled aborts without reporting an end
						setup_run <= 1'b0;
						as_state  <= AMS_AS_IDLE;
					end
				end
				AMS_AS_STORE: begin
					param_commit <= 1'b1;
					store_drive  <= 1'b1;
					store_tuning <= 1'b1;
					as_state     <= AMS_AS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			setup_ended <= 1'b0;
			index_found <= 1'b0;
		end else if ((as_state == AMS_AS_RUN) && setup_done) begin
			setup_ended <= 1'b1;
			index_found <= setup_index_found;
		end else if (as_start) begin
			// A new run forgets the result of the last one
			setup_ended <= 1'b0;
			index_found <= 1'b0;
		end
	end

	// ****************************************
	// Special drive modes
	// ****************************************
	ams_spd_if spd ();

	assign spd.code      = analog_code;
	assign spd.joystick  = sw_latched[1];
	assign spd.dir_ccw   = dir_s;
	assign spd.max_rpm   = sw_latched[2] ? `AMS_RPM_MAX_LO : `AMS_RPM_MAX_HI;
	assign spd.scale_num = scale_num;
	assign spd.scale_den = scale_den;

	ams_speed_calc u_speed (
		.clock (clock),
		.rst_n (rst_n),
		.spd   (spd.calc)
	);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			target_vel <= `AMS_TARGET_VEL_RST;
		end else if (mode == AMS_MODE_ANALOG) begin
			// Speed is zero while the enable input is low
			target_vel <= power_enabled ? spd.velocity : 32'h0000_0000;
		end else if (mode == AMS_MODE_TEST) begin
			if (!power_enabled) begin
				target_vel <= 32'h0000_0000;
			end else if (sw_latched[2]) begin
				target_vel <= 32'h0000_0000 - {16'h0000, `AMS_RPM_TEST};
			end else begin
				target_vel <= {16'h0000, `AMS_RPM_TEST};
			end
		end else if (wr && (addr == `AMS_ADDR_TARGET_VEL)) begin
			// Host speed only counts outside analog and test run
			target_vel <= wdata;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			step_pulse <= 1'b0;
			step_dir   <= 1'b0;
		end else begin
			// One step per rising edge of the clock pin in clock/direction mode while enabled
			step_pulse <= (mode == AMS_MODE_CLKDIR) && power_enabled && clk_s && !clk_prev;
			step_dir   <= dir_s;
		end
	end

endmodule // ams_top

`default_nettype wire

// >>> rtl/ams_regs.svh
`ifndef AMS_REGS_SVH
`define AMS_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define AMS_ADDR_CTRLWORD   8'h00
`define AMS_ADDR_STATUSWORD 8'h04
`define AMS_ADDR_OPMODE     8'h08
`define AMS_ADDR_PROGCTL    8'h0c
`define AMS_ADDR_SCALE_NUM  8'h10
`define AMS_ADDR_SCALE_DEN  8'h14
`define AMS_ADDR_TARGET_VEL 8'h18
`define AMS_ADDR_DRIVE_STAT 8'h1c

// ****************************************
// Field positions and codes
// ****************************************
`define AMS_CW_OMS_BIT      4
`define AMS_SW_OMS_BIT      12
`define AMS_SW_TARGET_REACHED_BIT_BIT     10
`define AMS_SW_OPEN_BIT     2
`define AMS_PROG_RUN_BIT    0
`define AMS_CW_STATE_MSB    3
`define AMS_CW_ENABLE_OP    4'hf
`define AMS_OPMODE_AUTOSET  8'hfe

// ****************************************
// Reset values
// ****************************************
`define AMS_CTRLWORD_RST    16'h0000
`define AMS_OPMODE_RST      8'h00
`define AMS_PROGCTL_RST     8'h00
`define AMS_SCALE_NUM_RST   16'h0001
`define AMS_SCALE_DEN_RST   16'h0001
`define AMS_TARGET_VEL_RST  32'h0000_0000

// ****************************************
// Speeds and analog scaling
// ****************************************
`define AMS_RPM_TEST        16'h001e
`define AMS_RPM_MAX_HI      16'h03e8
`define AMS_RPM_MAX_LO      16'h0064
`define AMS_ADC_FULL        12'hfff
`define AMS_ADC_MID         12'h800
`define AMS_ADC_DEAD        12'h008
`define AMS_SETTLE_CYCLES   2'h3

`endif

// >>> rtl/ams_pkg.sv
package ams_pkg;

	typedef enum logic [3:0] {
		AMS_MODE_NONE   = 4'b0001,
		AMS_MODE_CLKDIR = 4'b0010,
		AMS_MODE_TEST   = 4'b0100,
		AMS_MODE_ANALOG = 4'b1000
	} ams_mode_e;

	typedef enum logic [2:0] {
		AMS_AS_IDLE  = 3'b001,
		AMS_AS_RUN   = 3'b010,
		AMS_AS_STORE = 3'b100
	} ams_setup_e;

endpackage

// >>> rtl/ams_spd_if.sv
`timescale 1ns/100ps
`default_nettype none

interface ams_spd_if;
	logic [11:0] code;
	logic        joystick;
	logic        dir_ccw;
	logic [15:0] max_rpm;
	logic [15:0] scale_num;
	logic [15:0] scale_den;
	logic [31:0] velocity;

	modport ctl  (output code, joystick, dir_ccw, max_rpm, scale_num, scale_den, input velocity);
	modport calc (input code, joystick, dir_ccw, max_rpm, scale_num, scale_den, output velocity);
endinterface

`default_nettype wire

// >>> rtl/ams_speed_calc.sv
`timescale 1ns/100ps
`default_nettype none
`include "ams_regs.svh"

module ams_speed_calc
	import ams_pkg::*;
(
	input  wire logic clock,
	input  wire logic rst_n,
	ams_spd_if.calc   spd
);

	logic [11:0] excess;
	logic [11:0] span;
	logic        neg;
	logic [31:0] scaled;
	logic [15:0] max_eff;
	logic [27:0] prod;
	logic [15:0] mag;

	// ****************************************
	// Dead zone, direction and linear scaling
	// ****************************************
	always_comb begin
		excess = 12'h000;
		neg    = 1'b0;
		span   = `AMS_ADC_FULL - `AMS_ADC_DEAD;
		if (spd.joystick) begin
			span = `AMS_ADC_MID - `AMS_ADC_DEAD;
			if (spd.code > `AMS_ADC_MID + `AMS_ADC_DEAD) begin
				excess = spd.code - `AMS_ADC_MID - `AMS_ADC_DEAD;
			end else if (spd.code < `AMS_ADC_MID - `AMS_ADC_DEAD) begin
				excess = `AMS_ADC_MID - `AMS_ADC_DEAD - spd.code;
				neg    = 1'b1;
			end
		end else begin
			if (spd.code > `AMS_ADC_DEAD) begin
				excess = spd.code - `AMS_ADC_DEAD;
			end
			neg = spd.dir_ccw;
		end
		// Scaling factor replaces the switch maximum by max * num / den; a zero den keeps the switch maximum
		if (spd.scale_den == 16'h0000) begin
			scaled = {16'h0000, spd.max_rpm};
		end else begin
			scaled = ({16'h0000, spd.max_rpm} * {16'h0000, spd.scale_num})
				/ {16'h0000, spd.scale_den};
		end
		max_eff = (scaled > 32'h0000_ffff) ? 16'hffff : scaled[15:0];
		prod    = {16'h0000, excess} * {12'h000, max_eff};
		mag     = 16'(prod / {16'h0000, span});
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			spd.velocity <= 32'h0000_0000;
		end else if (neg) begin
			spd.velocity <= 32'h0000_0000 - {16'h0000, mag};
		end else begin
			spd.velocity <= {16'h0000, mag};
		end
	end

endmodule // ams_speed_calc

`default_nettype wire

// >>> bench/ams_partner.sv
`timescale 1ns/100ps
`default_nettype none

module ams_partner (
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic       setup_run,
	input  wire logic [7:0] delay,
	input  wire logic       ok_cfg,
	input  wire logic       idx_cfg,
	output logic            setup_done,
	output logic            setup_ok,
	output logic            setup_index_found
);
	logic [7:0] cnt;
	logic       fire;

	// ****************************************
	// Measurement engine: one done pulse per run
	// ****************************************
	assign fire = setup_run && !setup_done && cnt == delay;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 8'h00;
			setup_done <= 1'b0;
			setup_ok <= 1'b0;
			setup_index_found <= 1'b0;
		end else begin
			cnt <= (setup_run && !fire && !setup_done) ? cnt + 8'h01 : 8'h00;
			setup_done <= fire;
			// Qualifiers only meaningful beside done; toggle otherwise
			setup_ok <= fire ? ok_cfg : ~setup_ok;
			setup_index_found <= fire ? idx_cfg : ~setup_index_found;
		end
	end
endmodule // ams_partner

`default_nettype wire

// >>> bench/ams_monitor.sv
`timescale 1ns/100ps
`default_nettype none

module ams_monitor (
	input wire logic        clock,
	input wire logic        rst_n,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [31:0] rdata,
	input wire logic        enable_in,
	input wire logic        setup_done,
	input wire logic        setup_ok,
	input wire logic        setup_run,
	input wire logic        param_commit,
	input wire logic        store_drive,
	input wire logic        store_tuning,
	input wire logic        limits_active,
	input wire logic        power_enabled,
	input wire logic        velocity_mode,
	input wire logic        step_pulse
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	property p_start; $rose(setup_run) |-> $past(wr, 2); endproperty
	a_start: assert property (p_start) else $error("setup run without start write");
	property p_end; setup_run && setup_done |=> !setup_run; endproperty
	a_end: assert property (p_end) else $error("setup run not ended");
	property p_commit;
		setup_run && setup_done && setup_ok |-> ##2 (param_commit && store_drive && store_tuning);
	endproperty
	a_commit: assert property (p_commit) else $error("no store after success");
	property p_nocommit; setup_run && setup_done && !setup_ok |-> ##2 !param_commit; endproperty
	a_nocommit: assert property (p_nocommit) else $error("store after failed setup");
	property p_pulse; param_commit |=> !param_commit && !store_drive && !store_tuning; endproperty
	a_pulse: assert property (p_pulse) else $error("store pulse too long");
	property p_limits; $past(rst_n) |-> limits_active; endproperty
	a_limits: assert property (p_limits) else $error("range limits off");
	property p_power;
		velocity_mode && $past(velocity_mode, 3) |-> power_enabled == $past(enable_in, 3);
	endproperty
	a_power: assert property (p_power) else $error("power not following enable");
	property p_rdata; !$past(rd) |-> rdata == 32'h0000_0000; endproperty
	a_rdata: assert property (p_rdata) else $error("read data outside answer cycle");
	property p_step; step_pulse |=> !step_pulse; endproperty
	a_step: assert property (p_step) else $error("step pulse too long");

	c_commit: cover property (param_commit);
	c_step: cover property (step_pulse);
	c_speed: cover property (velocity_mode && power_enabled);
endmodule // ams_monitor

bind ams_top ams_monitor u_mon (.clock, .rst_n, .wr, .rd, .rdata, .enable_in, .setup_done,
	.setup_ok, .setup_run, .param_commit, .store_drive, .store_tuning, .limits_active,
	.power_enabled, .velocity_mode, .step_pulse);

`default_nettype wire

// >>> bench/test_ams_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "ams_regs.svh"

module test_ams_top;
	logic        clock = 1'b0;
	logic        rst_n, wr, rd, switch_disable_key, enable_in, clock_in, direction_in;
	logic        setup_done, setup_ok, setup_index_found, setup_run, ok_cfg, idx_cfg;
	logic        closed_loop, power_enabled, step_pulse, step_dir;
	logic [7:0]  addr, dly;
	logic [31:0] wdata, rdata;
	logic [31:0] steps = 32'h0;
	logic [3:0]  dip_switch;
	logic [11:0] analog_code;
	int          err_total = 0;
	int          compares = 0;
	int          cycles = 0;

	always #10 clock = ~clock;

	ams_top uut (.clock, .rst_n, .addr, .wdata, .wr, .rd, .rdata, .dip_switch,
		.switch_disable_key, .enable_in, .clock_in, .direction_in, .analog_code,
		.setup_done, .setup_ok, .setup_index_found, .setup_run, .param_commit(),
		.store_drive(), .store_tuning(), .limits_active(), .power_enabled, .closed_loop,
		.velocity_mode(), .step_pulse, .step_dir);

	ams_partner eng (.clock, .rst_n, .setup_run, .delay(dly), .ok_cfg, .idx_cfg,
		.setup_done, .setup_ok, .setup_index_found);

	// ****************************************
	// Access tasks
	// ****************************************
	task automatic report_and_stop;
		$display("errors %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clock);
		wr <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
		input logic [31:0] m = 32'hffff_ffff);
		@(posedge clock);
		rd <= 1'b1;
		addr <= a;
		@(posedge clock);
		rd <= 1'b0;
		#1 chk(rdata & m, exp);
	endtask

	task automatic restart(input logic [3:0] sw, input logic key);
		rst_n <= 1'b0;
		dip_switch <= sw;
		switch_disable_key <= key;
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		repeat (8) @(posedge clock);
	endtask

	task automatic wait_run(input logic lvl);
		int n;
		n = 0;
		while (setup_run !== lvl && n < 400) begin
			@(posedge clock);
			n++;
		end
		chk({31'h0, setup_run}, {31'h0, lvl});
	endtask

	task automatic start_setup(input logic [7:0] d, input logic ok, input logic idx);
		dly <= d;
		ok_cfg <= ok;
		idx_cfg <= idx;
		wr_reg(`AMS_ADDR_CTRLWORD, 32'h0000_000f);
		wr_reg(`AMS_ADDR_CTRLWORD, 32'h0000_001f);
		wait_run(1'b1);
	endtask

	task automatic try_code(input logic [11:0] c, input logic d, input logic [31:0] exp);
		analog_code <= c;
		direction_in <= d;
		repeat (6) @(posedge clock);
		rd_chk(`AMS_ADDR_TARGET_VEL, exp);
	endtask

	task automatic pulses(input int n);
		repeat (n) begin
			clock_in <= 1'b1;
			repeat (4) @(posedge clock);
			clock_in <= 1'b0;
			repeat (4) @(posedge clock);
		end
	endtask

	always @(posedge clock) begin
		if (step_pulse === 1'b1) begin
			steps <= steps + 32'h1;
		end
	end

	always @(posedge clock) begin
		cycles++;
		if (cycles == 6000) begin
			err_total++;
			report_and_stop;
		end
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		{rst_n, wr, rd, switch_disable_key, enable_in, clock_in, direction_in} = 7'h00;
		{ok_cfg, idx_cfg} = 2'h0;
		addr = 8'h00;
		wdata = 32'h0;
		dip_switch = 4'h0;
		analog_code = 12'h000;
		dly = 8'h00;
		restart(4'hf, 1'b1);
		chk({31'h0, closed_loop}, 32'h0);
		rd_chk(`AMS_ADDR_DRIVE_STAT, 32'h0000_0010, 32'h0000_0ff0);
		wr_reg(`AMS_ADDR_OPMODE, 32'h0000_00fe);
		wr_reg(`AMS_ADDR_PROGCTL, 32'h0000_0001);
		wr_reg(`AMS_ADDR_CTRLWORD, 32'h0000_000f);
		rd_chk(`AMS_ADDR_STATUSWORD, 32'h0000_0004);
		wr_reg(`AMS_ADDR_CTRLWORD, 32'h0000_001f);
		repeat (10) @(posedge clock);
		chk({31'h0, setup_run}, 32'h0);
		wr_reg(`AMS_ADDR_PROGCTL, 32'h0000_0000);
		start_setup(8'd0, 1'b1, 1'b1);
		wait_run(1'b0);
		rd_chk(`AMS_ADDR_STATUSWORD, 32'h0000_1404);
		start_setup(8'd200, 1'b1, 1'b0);
		rd_chk(`AMS_ADDR_STATUSWORD, 32'h0000_0004);
		wait_run(1'b0);
		rd_chk(`AMS_ADDR_STATUSWORD, 32'h0000_1004);
		start_setup(8'd5, 1'b0, 1'b1);
		wait_run(1'b0);
		wr_reg(`AMS_ADDR_STATUSWORD, 32'hffff_ffff);
		rd_chk(`AMS_ADDR_STATUSWORD, 32'h0000_1400, 32'h0000_fffb);
		wr_reg(8'h20, 32'h1234_5678);
		rd_chk(8'h20, 32'h0);

		restart(4'b1010, 1'b0);
		rd_chk(`AMS_ADDR_DRIVE_STAT, 32'h0000_0a41);
		chk({31'h0, closed_loop}, 32'h1);
		enable_in <= 1'b1;
		repeat (6) @(posedge clock);
		chk({31'h0, power_enabled}, 32'h1);
		rd_chk(`AMS_ADDR_TARGET_VEL, 32'h0000_001e);
		wr_reg(`AMS_ADDR_CTRLWORD, 32'h0000_000f);
		dip_switch <= 4'b0001;
		repeat (6) @(posedge clock);
		chk({31'h0, power_enabled}, 32'h1);
		rd_chk(`AMS_ADDR_DRIVE_STAT, 32'h0000_0a41);
		enable_in <= 1'b0;
		repeat (6) @(posedge clock);
		chk({31'h0, power_enabled}, 32'h0);
		rd_chk(`AMS_ADDR_TARGET_VEL, 32'h0);
		restart(4'b0110, 1'b0);
		enable_in <= 1'b1;
		repeat (6) @(posedge clock);
		rd_chk(`AMS_ADDR_TARGET_VEL, 32'hffff_ffe2);
		chk({31'h0, closed_loop}, 32'h0);

		restart(4'b0001, 1'b0);
		rd_chk(`AMS_ADDR_DRIVE_STAT, 32'h0000_0181);
		try_code(12'h008, 1'b0, 32'h0);
		try_code(12'hfff, 1'b0, 32'h0000_03e8);
		try_code(12'hfff, 1'b1, 32'hffff_fc18);
		wr_reg(`AMS_ADDR_SCALE_NUM, 32'h0000_0002);
		wr_reg(`AMS_ADDR_SCALE_DEN, 32'h0000_0005);
		try_code(12'hfff, 1'b0, 32'h0000_0190);
		restart(4'b0111, 1'b0);
		try_code(12'h800, 1'b0, 32'h0);
		try_code(12'h7f8, 1'b0, 32'h0);
		try_code(12'h808, 1'b0, 32'h0);
		try_code(12'h000, 1'b0, 32'hffff_ff9c);

		enable_in <= 1'b0;
		restart(4'b0100, 1'b0);
		rd_chk(`AMS_ADDR_DRIVE_STAT, 32'h0000_0421);
		pulses(5);
		chk(steps, 32'h0);
		enable_in <= 1'b1;
		direction_in <= 1'b1;
		repeat (4) @(posedge clock);
		pulses(5);
		chk(steps, 32'h5);
		chk({31'h0, step_dir}, 32'h1);
		report_and_stop;
	end
endmodule // test_ams_top

`default_nettype wire
